// ---- logic/nv_sram_spi_slave_recall_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// - Supply rising starts nonvolatile to SRAM copy
// - Power-up copy blocks access, busy pin
// - Recall opcode copies, blocks memory access
// - Save-off opcode clears power-loss save
// - Save-on opcode sets power-loss save
// - Save setting volatile unless stored afterwards
// - Power-loss save enabled out of reset
// - Power-up copy always runs
// - Serial clock at most the stated rate
// - Sample on rise, drive on fall
// - First byte after select is opcode
// - Deselected: ignore input, output floats
// - Most significant bit first everywhere
// - Three address bytes, low 17 used
// - Bad opcode: ignore until next select
// - Clock level at select picks mode
// - Mode 3 waits for clock fall first
// - Slave only, never starts traffic
// - Recall, save-on, save-off opcode values
// - Busy pin low, ready bit high
// - Stay deselected until select falling edge
module nv_sram_spi_slave_recall_ctrl #(
  parameter nv_spi_pkg::count_t POWER_UP_COPY_CYCLES = nv_spi_pkg::POWER_UP_COPY_CYC,
  parameter nv_spi_pkg::count_t RECALL_CYCLES = nv_spi_pkg::RECALL_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic soOut,
  output logic soOeN,
  // Busy pin, open drain
  output logic busyPinOut,
  output logic busyPinOeN,
  // SRAM port
  output logic memRead,
  output logic memWrite,
  output nv_spi_pkg::addr_t memAddr,
  output nv_spi_pkg::byte_t memWrData,
  input wire nv_spi_pkg::byte_t memRdData,
  // Store sequencer and status
  input wire logic storeBusy,
  input wire logic nvAutosave,
  output logic storeReq,
  output logic autosaveEn,
  output logic readyBit
);
  import nv_spi_pkg::*;

  // All controller state
  typedef struct packed {
    logic csPrev;
    logic sckPrev;
    logic selected;
    logic mode3;
    logic armed;
    phase_t phase;
    logic isRead;
    logic [2:0] bitCnt;
    logic [1:0] addrBytes;
    byte_t rxShift;
    byte_t txShift;
    addr_t addr;
    addr_t memAddr;
    byte_t memWrData;
    logic loadPending;
    logic memRead;
    logic memWrite;
    logic soOut;
    logic soOeN;
    logic autosaveEn;
    logic porPending;
    logic copyStart;
    logic copyPowerUp;
    logic storeReq;
    logic readyBit;
    logic busyOeN;
  } ctrl_t;

  ctrl_t s_ff;
  ctrl_t nxt_s;
  // Synchronised pins
  logic [2:0] pinSync;
  logic csS;
  logic sckS;
  logic siS;
  // Edge and event helpers
  logic rise;
  logic fall;
  logic selFall;
  logic busyNow;
  logic inBit;
  logic opDone;
  byte_t rxByte;

  copy_if cp ();

  // Next address with rollover at the top
  function automatic addr_t nextAddr(input addr_t a);
    nextAddr = a + addr_t'(1);
  endfunction: nextAddr

  // Pins pass two flops before use
  pin_sync #(.W(3)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pinIn({csN, sck, si}),
    .pinOut(pinSync)
  );

  // Copy duration counter
  copy_timer u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cp(cp)
  );

  assign csS = pinSync[2];
  assign sckS = pinSync[1];
  assign siS = pinSync[0];
  assign rise = !s_ff.sckPrev && sckS;
  assign fall = s_ff.sckPrev && !sckS;
  // Only a seen high-to-low counts as select
  assign selFall = s_ff.csPrev && !csS;
  // Any copy or store in progress
  assign busyNow = s_ff.porPending || s_ff.copyStart || cp.busy || storeBusy;
  // A sampled input bit in a receiving phase
  assign inBit = !csS && s_ff.selected && s_ff.armed && rise
    && (s_ff.phase == PH_OPCODE || s_ff.phase == PH_ADDR || (s_ff.phase == PH_DATA && !s_ff.isRead));
  // Shift in, most significant bit first
  assign rxByte = {s_ff.rxShift[6:0], siS};
  assign opDone = inBit && s_ff.phase == PH_OPCODE && s_ff.bitCnt == 3'h7;

  assign cp.start = s_ff.copyStart;
  assign cp.count = s_ff.copyPowerUp ? POWER_UP_COPY_CYCLES : RECALL_CYCLES;

  // Serial decoder, copy control and save latch
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.copyStart = 1'b0;
    nxt_s.memRead = 1'b0;
    nxt_s.memWrite = 1'b0;
    nxt_s.storeReq = 1'b0;
    nxt_s.csPrev = csS;
    nxt_s.sckPrev = sckS;
    // Busy pin pulled low, ready bit set
    nxt_s.readyBit = busyNow;
    nxt_s.busyOeN = !busyNow;
    if (s_ff.porPending)
    begin
      nxt_s.porPending = 1'b0;
      nxt_s.copyStart = 1'b1;
      nxt_s.copyPowerUp = 1'b1;
    end
    // Any finished copy reloads the save latch
    if (cp.done)
    begin
      nxt_s.autosaveEn = nvAutosave;
    end
    if (csS)
    begin
      nxt_s.selected = 1'b0;
      nxt_s.phase = PH_IDLE;
      nxt_s.soOeN = 1'b1;
      nxt_s.loadPending = 1'b0;
    end
    else if (selFall)
    begin
      // Clock level at select picks the mode
      nxt_s.selected = 1'b1;
      nxt_s.phase = PH_OPCODE;
      nxt_s.mode3 = sckS;
      nxt_s.armed = !sckS;
      nxt_s.bitCnt = 3'h0;
      nxt_s.soOeN = 1'b1;
    end
    else if (s_ff.selected)
    begin
      // Mode 3 counts rises only after a fall
      if (fall && !s_ff.armed)
      begin
        nxt_s.armed = 1'b1;
      end
      // Read data stands the cycle after the strobe, so skip the strobe cycle
      if (s_ff.loadPending && !s_ff.memRead)
      begin
        nxt_s.loadPending = 1'b0;
        nxt_s.txShift = memRdData;
      end
      // Input bits taken on rising edges
      if (inBit)
      begin
        nxt_s.rxShift = rxByte;
        nxt_s.bitCnt = s_ff.bitCnt + 3'h1;
        if (s_ff.bitCnt == 3'h7)
        begin
          unique case (s_ff.phase)
            PH_OPCODE:
            begin
              nxt_s.phase = PH_IGNORE;
              case (rxByte)
                OPC_RECALL:
                begin
                  if (!busyNow)
                  begin
                    nxt_s.copyStart = 1'b1;
                    nxt_s.copyPowerUp = 1'b0;
                  end
                end
                OPC_STORE:
                begin
                  nxt_s.storeReq = !busyNow;
                end
                OPC_SAVE_ON:
                begin
                  nxt_s.autosaveEn = 1'b1;
                end
                OPC_SAVE_OFF:
                begin
                  nxt_s.autosaveEn = 1'b0;
                end
                OPC_READ, OPC_WRITE:
                begin
                  // Access during a copy is refused
                  nxt_s.phase = busyNow ? PH_IGNORE : PH_ADDR;
                  nxt_s.isRead = rxByte == OPC_READ;
                  nxt_s.addrBytes = 2'h0;
                end
                default:
                begin
                  nxt_s.phase = PH_IGNORE;
                end
              endcase
            end
            PH_ADDR:
            begin
              // Upper seven address bits fall away
              nxt_s.addr = {s_ff.addr[8:0], rxByte};
              nxt_s.addrBytes = s_ff.addrBytes + 2'h1;
              if (s_ff.addrBytes == 2'h2)
              begin
                nxt_s.phase = PH_DATA;
                nxt_s.memAddr = {s_ff.addr[8:0], rxByte};
                nxt_s.memRead = s_ff.isRead;
                nxt_s.loadPending = s_ff.isRead;
              end
            end
            PH_DATA:
            begin
              // Write one byte, then step the address
              nxt_s.memWrite = 1'b1;
              nxt_s.memWrData = rxByte;
              nxt_s.memAddr = s_ff.addr;
              nxt_s.addr = nextAddr(s_ff.addr);
            end
            default:
            begin
              nxt_s.phase = PH_IGNORE;
            end
          endcase
        end
      end
      // Output only for a read, changed on falls
      if (fall && s_ff.armed && s_ff.phase == PH_DATA && s_ff.isRead)
      begin
        nxt_s.soOut = nxt_s.txShift[7];
        nxt_s.soOeN = 1'b0;
        nxt_s.txShift = {nxt_s.txShift[6:0], 1'b0};
        nxt_s.bitCnt = s_ff.bitCnt + 3'h1;
        // Fetch the next byte during the last bit
        if (s_ff.bitCnt == 3'h7)
        begin
          nxt_s.addr = nextAddr(s_ff.addr);
          nxt_s.memAddr = nextAddr(s_ff.addr);
          nxt_s.memRead = 1'b1;
          nxt_s.loadPending = 1'b1;
        end
      end
    end
    if (busyNow)
    begin
      nxt_s.memRead = 1'b0;
      nxt_s.memWrite = 1'b0;
    end
  end

  // Register state; save enabled and copy pending after reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
      s_ff.autosaveEn <= AUTOSAVE_RST;
      s_ff.porPending <= 1'b1;
      s_ff.soOeN <= 1'b1;
      s_ff.busyOeN <= 1'b1;
      s_ff.phase <= PH_IDLE;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Output drive
  assign soOut = s_ff.soOut;
  assign soOeN = s_ff.soOeN;
  assign busyPinOut = 1'b0;
  assign busyPinOeN = s_ff.busyOeN;
  assign memRead = s_ff.memRead;
  assign memWrite = s_ff.memWrite;
  assign memAddr = s_ff.memAddr;
  assign memWrData = s_ff.memWrData;
  assign storeReq = s_ff.storeReq;
  // Volatile setting handed to the store path
  assign autosaveEn = s_ff.autosaveEn;
  assign readyBit = s_ff.readyBit;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_por_copy_start: assert property (s_ff.porPending |-> ##2 cp.busy && s_ff.copyPowerUp)
    else $error("power-up copy not started");
  a_busy_pin_low: assert property (cp.busy |=> !busyPinOeN && readyBit)
    else $error("busy not shown");
  a_mem_refused: assert property (busyNow |=> !memRead && !memWrite)
    else $error("memory access while busy");
  a_recall_cmd: assert property (opDone && rxByte == OPC_RECALL && !busyNow |=> s_ff.copyStart ##1 cp.busy)
    else $error("recall not started");
  a_save_off: assert property (opDone && rxByte == OPC_SAVE_OFF |=> !autosaveEn)
    else $error("save not disabled");
  a_save_on: assert property (opDone && rxByte == OPC_SAVE_ON |=> autosaveEn)
    else $error("save not enabled");
  a_save_reset: assert property (s_ff.porPending |-> autosaveEn)
    else $error("save not enabled at reset");
  a_latch_reload: assert property (cp.done && !opDone |=> autosaveEn == $past(nvAutosave))
    else $error("save latch not reloaded");
  a_so_float: assert property (csS |=> soOeN && !s_ff.selected)
    else $error("output driven while deselected");
  a_mode_pick: assert property (selFall |=> s_ff.mode3 == $past(sckS) && s_ff.phase == PH_OPCODE)
    else $error("mode not taken at select");
  a_opcode_first: assert property (opDone && rxByte == OPC_WRITE && !busyNow |=> s_ff.phase == PH_ADDR)
    else $error("opcode not decoded");
  a_bad_ignored: assert property (s_ff.phase == PH_IGNORE && !csS |=> s_ff.phase == PH_IGNORE && soOeN)
    else $error("ignored transfer resumed");
  a_stay_idle: assert property (!s_ff.selected && !selFall |=> !s_ff.selected)
    else $error("selected without falling edge");
  a_so_on_fall: assert property ($changed(soOut) |-> $past(fall))
    else $error("output changed off a fall");

  c_read_byte: cover property (s_ff.memRead && s_ff.isRead ##[1:400] s_ff.memRead);
  c_write_byte: cover property (s_ff.memWrite);
  c_recall: cover property (s_ff.copyStart && !s_ff.copyPowerUp);
  c_mode3: cover property (selFall && sckS);
endmodule: nv_sram_spi_slave_recall_ctrl

// ---- pkg/nv_spi_pkg.sv ----
package nv_spi_pkg;
  // Core clock rate
  localparam int unsigned CORE_CLK_MHZ = 25;
  // Highest serial clock rate the master may use
  localparam int unsigned SCK_MAX_MHZ = 30;
  // Copy times, in ns
  localparam int unsigned POWER_UP_COPY_TIME_NS = 20000000;
  localparam int unsigned RECALL_TIME_NS = 200000;
  // Copy times in core cycles, rounded up
  localparam int unsigned POWER_UP_COPY_CYC = (POWER_UP_COPY_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned RECALL_CYC = (RECALL_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  // Widths
  localparam int ADDR_W = 17;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 32;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_STORE = 8'h3C;
  localparam logic [7:0] OPC_RECALL = 8'h60;
  localparam logic [7:0] OPC_SAVE_ON = 8'h59;
  localparam logic [7:0] OPC_SAVE_OFF = 8'h19;
  // Reset values
  localparam logic AUTOSAVE_RST = 1'b1;
  localparam logic [2:0] PIN_SYNC_RST = 3'h0;
  // Transaction phases
  typedef enum logic [2:0] {PH_IDLE, PH_OPCODE, PH_ADDR, PH_DATA, PH_IGNORE} phase_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [BYTE_W-1:0] byte_t;
  typedef logic [CNT_W-1:0] count_t;
endpackage: nv_spi_pkg

// ---- pkg/copy_if.sv ----
`timescale 1ns/1ps
// Link between the controller and the copy timer
interface copy_if;
  // Start pulse and length in cycles
  logic start;
  nv_spi_pkg::count_t count;
  // Copy running, and end pulse
  logic busy;
  logic done;
  modport ctrl (output start, output count, input busy, input done);
  modport timer (input start, input count, output busy, output done);
endinterface: copy_if

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Raw pins and synchronised copies
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  import nv_spi_pkg::*;

  // Two stages per pin
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_t;

  sync_t s_ff;
  sync_t nxt_s;

  // Shift pins through both stages
  always_comb
  begin
    nxt_s.stage1 = pinIn;
    nxt_s.stage2 = s_ff.stage1;
  end

  // Register stages
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign pinOut = s_ff.stage2;
endmodule: pin_sync

// ---- logic/copy_timer.sv ----
`timescale 1ns/1ps
module copy_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Controller side
  copy_if.timer cp
);
  import nv_spi_pkg::*;

  // Remaining cycles, running flag, end pulse
  typedef struct packed {
    count_t left;
    logic busy;
    logic done;
  } timer_t;

  timer_t s_ff;
  timer_t nxt_s;

  // Count the copy down; a start while busy is dropped
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (s_ff.busy)
    begin
      // Last cycle of the copy
      if (s_ff.left <= count_t'(1))
      begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
      else
      begin
        nxt_s.left = s_ff.left - count_t'(1);
      end
    end
    else if (cp.start)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.left = cp.count;
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign cp.busy = s_ff.busy;
  assign cp.done = s_ff.done;

  a_copy_runs: assert property (@(posedge core_clk) disable iff (!reset_n)
    cp.start && !s_ff.busy |=> s_ff.busy && s_ff.left == $past(cp.count))
    else $error("copy did not start");
endmodule: copy_timer

// ---- sim/spi_master.sv ----
`timescale 1ns/1ps
// Serial bus master driving the slave pins
module spi_master (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic csN,
  output logic sck,
  output logic si,
  input wire logic soOut,
  input wire logic soOeN
);
  import nv_spi_pkg::*;
  // Last seen SO level
  logic lastSo = 1'b0;
  // Released SO toggles, never holds old data
  logic soWire;
  assign soWire = soOeN ? ~lastSo : soOut;
  // Track line level every cycle
  always @(posedge core_clk)
  begin
    lastSo <= soWire;
  end
  // Idle bus at time zero
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Wait n falling core edges
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask: tick
  task automatic sel(input logic mode);
    sck = mode;
    tick(4);
    csN = 1'b0;
    tick(4);
  endtask: sel
  task automatic desel(input logic mode);
    tick(4);
    sck = mode;
    tick(4);
    csN = 1'b1;
    si = ~si;
    tick(8);
  endtask: desel
  // MSB first, 320 ns bit time
  task automatic xb(input byte_t tx, output byte_t rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si = tx[i];
      tick(4);
      sck = 1'b1;
      rx[i] = soWire;
      tick(4);
    end
  endtask: xb
endmodule: spi_master

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// Self-checking bench for the serial front end
module tb_top;
  import nv_spi_pkg::*;
  // Shortened copy times
  localparam int PUC = 400;
  localparam int RC = 600;
  // Clock, reset and pins
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic csN, sck, si, soOut, soOeN, busyPinOut, busyPinOeN, busyWire;
  logic memRead, memWrite, storeReq, autosaveEn, readyBit;
  logic storeBusy = 1'b0;
  logic nvAutosave = 1'b1;
  addr_t memAddr;
  byte_t memWrData;
  byte_t memRdData = 8'h00;
  // Counters and captured writes
  int errCount = 0;
  int cmpCount = 0;
  int cyc = 0;
  int stCnt = 0;
  int soLow = 0;
  int rdCnt = 0;
  logic [24:0] wq[$];
  // Open-drain busy pin with pull-up
  assign busyWire = busyPinOeN ? 1'b1 : busyPinOut;
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  nv_sram_spi_slave_recall_ctrl #(.POWER_UP_COPY_CYCLES(PUC), .RECALL_CYCLES(RC)) nv_sram_spi_slave_recall_ctrl_inst (
    .core_clk(core_clk), .reset_n(reset_n), .csN(csN), .sck(sck), .si(si), .soOut(soOut),
    .soOeN(soOeN), .busyPinOut(busyPinOut), .busyPinOeN(busyPinOeN), .memRead(memRead),
    .memWrite(memWrite), .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
    .storeBusy(storeBusy), .nvAutosave(nvAutosave), .storeReq(storeReq),
    .autosaveEn(autosaveEn), .readyBit(readyBit));
  spi_master spi_master_inst (.core_clk(core_clk), .csN(csN), .sck(sck), .si(si),
    .soOut(soOut), .soOeN(soOeN));
  // SRAM model, strobe capture and timeout
  always @(posedge core_clk)
  begin
    if (memWrite === 1'b1) wq.push_back({memAddr, memWrData});
    if (memRead === 1'b1) memRdData <= memAddr[7:0] ^ 8'h5A;
    if (memRead === 1'b1) rdCnt++;
    if (storeReq === 1'b1) stCnt++;
    if (soOeN === 1'b0) soLow++;
    cyc++;
    if (cyc == 20000)
    begin
      errCount++;
      summarize();
    end
  end
  // Verdict and end of run
  task automatic summarize();
    if (errCount == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask: summarize
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask: chk
  // One selection carrying the given bytes
  task automatic frame(input logic mode, input byte_t tx[$], output byte_t rx);
    spi_master_inst.sel(mode);
    foreach (tx[i]) spi_master_inst.xb(tx[i], rx);
    spi_master_inst.desel(mode);
  endtask: frame
  // Master waits out any copy, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    while (readyBit !== 1'b0 && n < 2000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("busyCleared", readyBit, 0);
  endtask: wait_idle
  task automatic t_powerup(input int t0);
    byte_t r;
    repeat (3) @(negedge core_clk);
    chk("readyBit", readyBit, 1);
    chk("busyPin", busyWire, 0);
    chk("autosaveEn", autosaveEn, 1);
    // Upper address bits sent as zero
    frame(0, '{OPC_WRITE, 8'h00, 8'h00, 8'h10, 8'hC3}, r);
    chk("writesWhileBusy", wq.size(), 0);
    wait_idle();
    chk("copyLength", (cyc - t0 >= PUC) && (cyc - t0 <= PUC + 6), 1);
    chk("busyPinIdle", busyWire, 1);
  endtask: t_powerup
  task automatic t_autosave();
    byte_t r;
    frame(0, '{OPC_SAVE_OFF}, r);
    chk("saveOff", autosaveEn, 0);
    frame(0, '{OPC_SAVE_ON}, r);
    chk("saveOn", autosaveEn, 1);
    frame(1, '{OPC_STORE}, r);
    chk("storeReq", stCnt, 1);
    storeBusy = 1'b1;
    repeat (4) @(negedge core_clk);
    chk("storeReady", readyBit, 1);
    chk("storePin", busyWire, 0);
    storeBusy = 1'b0;
    wait_idle();
  endtask: t_autosave
  task automatic t_recall();
    byte_t r;
    nvAutosave = 1'b0;
    frame(0, '{OPC_RECALL}, r);
    chk("recallReady", readyBit, 1);
    chk("recallPin", busyWire, 0);
    frame(0, '{OPC_WRITE, 8'h00, 8'h00, 8'h20, 8'h11}, r);
    chk("recallWrites", wq.size(), 0);
    wait_idle();
    chk("reloaded", autosaveEn, 0);
    nvAutosave = 1'b1;
  endtask: t_recall
  // Burst write across the top address
  task automatic t_write();
    byte_t r;
    frame(0, '{OPC_WRITE, 8'h01, 8'hFF, 8'hFF, 8'hA5, 8'h3C}, r);
    chk("writeCount", wq.size(), 2);
    chk("writeTop", wq[0], {17'h1FFFF, 8'hA5});
    chk("writeWrap", wq[1], {17'h00000, 8'h3C});
  endtask: t_write
  // Reads in mode 3 and mode 0
  task automatic t_read();
    byte_t r;
    frame(1, '{OPC_READ, 8'hFE, 8'h00, 8'h05, 8'h00}, r);
    chk("readMode3", r, 8'h5F);
    frame(0, '{OPC_READ, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00}, r);
    chk("readMode0", r, 8'h81 ^ 8'h5A);
    chk("soReleased", soOeN, 1);
  endtask: t_read
  task automatic t_badop();
    byte_t r;
    int s0, r0;
    wq.delete();
    s0 = soLow;
    r0 = rdCnt;
    frame(0, '{8'h1E, OPC_WRITE, OPC_READ, 8'h00, 8'h00, 8'h77}, r);
    chk("badWrites", wq.size(), 0);
    chk("badReads", rdCnt - r0, 0);
    chk("badSo", soLow - s0, 0);
  endtask: t_badop
  // Main sequence
  initial
  begin
    int t0;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    t0 = cyc;
    t_powerup(t0);
    t_autosave();
    t_recall();
    t_write();
    t_read();
    t_badop();
    summarize();
  end
endmodule: tb_top
